// File: rtl/ext_bus_consts.svh
/*
  constants for the external bus data, termination and arbitration block.
  assumes inclusion by bare name from the package only; the design modules rely on its compilation unit.
*/
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define DATA_W        32
`define LANES         4
`define LANE_W        8
`define FIFO_DEPTH    8
`define FIFO_AW       3
`define SIZE_WORD     2'h0
`define SIZE_BYTE     2'h1
`define SIZE_HALF     2'h2
`define SIZE_TRIPLE   2'h3
`define LANES_NONE    4'h0
`define LANES_ALL     4'hf
`define LANES_BYTE    4'h1
`define LANES_HALF    4'h3
`define LANES_TRIPLE  4'h7
`endif

// File: rtl/ext_bus_pkg.sv
/*
  types shared by the external bus block and its fifo.
  assumes the constants header is on the include path.
*/
`include "ext_bus_consts.svh"
package ext_bus_pkg;
  // one write request from the core side
  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic [1:0]         addr_lo;
    logic [1:0]         size_code;
    logic               burst;
  } wr_req_t;

  // one captured read beat
  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic [`LANES-1:0]  lanes;
    logic               par_err;
    logic               bus_err;
    logic               no_burst;
  } rd_beat_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_OWN   = 3'b010,
    ST_WR    = 3'b011,
    ST_RD    = 3'b100,
    ST_GRANT = 3'b101
  } bus_state_t;
endpackage

// File: rtl/ext_bus_fifo.sv
/*
  generic synchronous fifo with valid and ready on both sides.
  assumes one clock and an active-low asynchronous reset already synchronised.
*/
`timescale 1ns/1ps
module ext_bus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  // honest full and empty from the fill count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset, contents are qualified by the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

// File: rtl/ext_bus_lane_sel.sv
/*
  lane select and per-lane parity for the external data bus.
  assumes a combinational use inside the bus block, no clock.
*/
`timescale 1ns/1ps
module ext_bus_lane_sel
  import ext_bus_pkg::*;
(
  // transfer description
  input  wire logic [1:0]         addr_lo_i,
  input  wire logic [1:0]         size_code_i,
  input  wire logic               burst_i,
  input  wire logic               odd_i,
  input  wire logic [`DATA_W-1:0] data_i,
  // results
  output logic [`LANES-1:0]       lanes_o,
  output logic [`LANES-1:0]       parity_o
);
  logic [`LANES-1:0] base;

  // lanes selected by size, shifted by the low address bits
  always_comb begin
    case (size_code_i)
      `SIZE_BYTE:   base = `LANES_BYTE;
      `SIZE_HALF:   base = `LANES_HALF;
      `SIZE_TRIPLE: base = `LANES_TRIPLE;
      default:      base = `LANES_ALL;
    endcase
    if (burst_i || size_code_i == `SIZE_WORD) begin
      lanes_o = `LANES_ALL; // bursts use every lane
    end else begin
      lanes_o = `LANES'(base << addr_lo_i);
    end
  end

  // lane n is data bits n*8 up to n*8+7
  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane
      assign parity_o[g] = ^data_i[g*`LANE_W +: `LANE_W] ^ odd_i;
    end
  endgenerate
endmodule

// File: rtl/ext_bus_term_arb.sv
/*
  data lane drive, parity, termination and arbitration for the external bus.
  assumes all bus pins are synchronous to CLK_I, two-way pins split in three
  signals, and that the core offers writes and reads one at a time.
*/
`timescale 1ns/1ps
module ext_bus_term_arb
  import ext_bus_pkg::*;
(
  // clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RESET_N_I,
  // configuration
  input  wire logic               INT_ARB_EN_I,
  input  wire logic               PARKED_I,
  input  wire logic               PAR_ODD_I,
  input  wire logic               PAR_CHK_EN_I,
  input  wire logic               MC_SLAVE_I,
  input  wire logic               MC_EXT_MASTER_I,
  input  wire logic               MON_ERR_I,
  input  wire logic               MC_NO_BURST_I,
  // core write request
  input  wire logic               WR_VALID_I,
  output logic                    WR_READY_O,
  input  wire logic [`DATA_W-1:0] WR_DATA_I,
  input  wire logic [1:0]         WR_ADDR_LO_I,
  input  wire logic [1:0]         WR_SIZE_I,
  input  wire logic               WR_BURST_I,
  // core read request and result
  input  wire logic               RD_REQ_I,
  input  wire logic [1:0]         RD_ADDR_LO_I,
  input  wire logic [1:0]         RD_SIZE_I,
  input  wire logic               RD_BURST_I,
  output logic                    RD_VALID_O,
  output logic [`DATA_W-1:0]      RD_DATA_O,
  output logic                    RD_PAR_ERR_O,
  output logic                    RD_BUS_ERR_O,
  output logic                    RD_NO_BURST_O,
  output logic                    BEAT_DONE_O,
  // external master snoop
  output logic                    SNOOP_VALID_O,
  output logic [`DATA_W-1:0]      SNOOP_DATA_O,
  output logic                    EXT_TENURE_END_O,
  // data and parity pins
  input  wire logic [`DATA_W-1:0] DATA_I,
  output logic [`DATA_W-1:0]      DATA_O,
  output logic                    DATA_OE_O,
  input  wire logic [`LANES-1:0]  PARITY_LINES_I,
  output logic [`LANES-1:0]       PARITY_LINES_O,
  output logic                    PARITY_LINES_OE_O,
  // termination pins, active low
  input  wire logic               TRANSFER_ACK_N_I,
  output logic                    TRANSFER_ACK_N_O,
  output logic                    TRANSFER_ACK_OE_O,
  input  wire logic               ERROR_ACK_N_I,
  output logic                    ERROR_ACK_N_O,
  output logic                    ERROR_ACK_OE_O,
  input  wire logic               NO_BURST_REPLY_N_I,
  output logic                    NO_BURST_REPLY_N_O,
  output logic                    NO_BURST_REPLY_OE_O,
  // arbitration pins, active low
  input  wire logic               BUS_REQUEST_N_I,
  output logic                    BUS_REQUEST_N_O,
  output logic                    BUS_REQUEST_OE_O,
  input  wire logic               BUS_GRANT_N_I,
  output logic                    BUS_GRANT_N_O,
  output logic                    BUS_GRANT_OE_O,
  input  wire logic               BUS_BUSY_N_I,
  output logic                    BUS_BUSY_N_O,
  output logic                    BUS_BUSY_OE_O
);
  // reset release through two flops
  logic rst_s1_r, rst_n;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // pin inputs: three flops, change accepted when stages two and three agree
  localparam int PW = `DATA_W + `LANES + 6;
  logic [PW-1:0] pin_raw, s1_r, s2_r, s3_r, pin_r, pin_nxt;
  assign pin_raw = {DATA_I, PARITY_LINES_I, TRANSFER_ACK_N_I, ERROR_ACK_N_I,
                    NO_BURST_REPLY_N_I, BUS_REQUEST_N_I, BUS_GRANT_N_I, BUS_BUSY_N_I};
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      pin_r <= '1;
    end else begin
      s1_r  <= pin_raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= pin_nxt;
    end
  end
  logic [`DATA_W-1:0] d_in;
  logic [`LANES-1:0]  p_in;
  logic               ack_in, err_in, nob_in, req_in, gnt_in, busy_in;
  assign {d_in, p_in, ack_in, err_in, nob_in, req_in, gnt_in, busy_in} = pin_r;

  // write requests queue in the fifo; its ready stalls the core
  wr_req_t wr_in, wr_head;
  logic    wr_head_valid, wr_pop;
  assign wr_in = '{data: WR_DATA_I, addr_lo: WR_ADDR_LO_I, size_code: WR_SIZE_I, burst: WR_BURST_I};
  logic wr_ready, wr_take;
  // take only on the registered ready the core sees, so a held push lands once
  assign wr_take = WR_VALID_I & WR_READY_O;
  ext_bus_fifo #(.WIDTH($bits(wr_req_t)), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_wr_fifo (
    .clk       (CLK_I),
    .rst_n     (rst_n),
    .in_valid  (wr_take),
    .in_ready  (wr_ready),
    .in_data   (wr_in),
    .out_valid (wr_head_valid),
    .out_ready (wr_pop),
    .out_data  (wr_head)
  );

  // held read request
  logic       rd_pend_r, rd_pend_nxt, rd_burst_r, rd_burst_nxt;
  logic [1:0] rd_lo_r, rd_lo_nxt, rd_sz_r, rd_sz_nxt;

  // lane select and parity for the active transfer
  bus_state_t st_r, st_nxt;
  logic [`LANES-1:0] lanes, par_gen, rd_lanes, rd_par;
  ext_bus_lane_sel u_wr_sel (
    .addr_lo_i   (wr_head.addr_lo),
    .size_code_i (wr_head.size_code),
    .burst_i     (wr_head.burst),
    .odd_i       (PAR_ODD_I),
    .data_i      (wr_head.data),
    .lanes_o     (lanes),
    .parity_o    (par_gen)
  );
  ext_bus_lane_sel u_rd_sel (
    .addr_lo_i   (rd_lo_r),
    .size_code_i (rd_sz_r),
    .burst_i     (rd_burst_r),
    .odd_i       (PAR_ODD_I),
    .data_i      (d_in),
    .lanes_o     (rd_lanes),
    .parity_o    (rd_par)
  );

  // beat ends on slave or controller acknowledge, or on an error
  logic ack_beat, err_beat, nob_beat;
  // own reads wait for the looped-back ack, so the filtered lanes have arrived
  assign ack_beat = (MC_SLAVE_I && st_r == ST_WR) | ~ack_in;
  assign err_beat = MON_ERR_I | ~err_in;
  assign nob_beat = MC_SLAVE_I ? MC_NO_BURST_I : ~nob_in;
  logic end_beat;
  assign end_beat = ack_beat | err_beat;
  logic qual_grant;
  assign qual_grant = ~gnt_in & busy_in;

  // arbitration and transfer state
  logic want;
  assign want = wr_head_valid | rd_pend_r;
  always_comb begin
    st_nxt       = st_r;
    rd_pend_nxt  = rd_pend_r;
    rd_lo_nxt    = rd_lo_r;
    rd_sz_nxt    = rd_sz_r;
    rd_burst_nxt = rd_burst_r;
    wr_pop       = 1'b0;
    if (RD_REQ_I && !rd_pend_r) begin
      rd_pend_nxt  = 1'b1;
      rd_lo_nxt    = RD_ADDR_LO_I;
      rd_sz_nxt    = RD_SIZE_I;
      rd_burst_nxt = RD_BURST_I;
    end
    case (st_r)
      ST_IDLE: begin
        if (INT_ARB_EN_I && !req_in) begin
          st_nxt = ST_GRANT;
        end else if (want) begin
          st_nxt = INT_ARB_EN_I ? ST_OWN : ST_REQ;
        end
      end
      ST_REQ: begin
        if (INT_ARB_EN_I) begin
          st_nxt = ST_IDLE;
        end else if (qual_grant || PARKED_I) begin
          st_nxt = ST_OWN;
        end
      end
      ST_OWN: begin
        st_nxt = wr_head_valid ? ST_WR : (rd_pend_r ? ST_RD : ST_IDLE);
      end
      ST_WR: begin
        if (end_beat) begin
          wr_pop = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_RD: begin
        if (end_beat) begin
          rd_pend_nxt = 1'b0;
          st_nxt      = ST_IDLE;
        end
      end
      ST_GRANT: begin
        if (!busy_in) begin
          st_nxt = ST_GRANT; // external tenure in progress
        end else if (req_in) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= ST_IDLE;
      rd_pend_r  <= 1'b0;
      rd_lo_r    <= 2'h0;
      rd_sz_r    <= 2'h0;
      rd_burst_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      rd_pend_r  <= rd_pend_nxt;
      rd_lo_r    <= rd_lo_nxt;
      rd_sz_r    <= rd_sz_nxt;
      rd_burst_r <= rd_burst_nxt;
    end
  end

  // registered pin and result outputs
  typedef struct packed {
    logic [`DATA_W-1:0] dat;
    logic               doe;
    logic [`LANES-1:0]  par;
    logic               ack_n, ack_oe, err_n, err_oe, nob_n, nob_oe;
    logic               req_n, req_oe, gnt_n, gnt_oe, busy_n, busy_oe;
    logic               wr_rdy;
    rd_beat_t           rd;
    logic               rd_v, beat, snp_v, ten_end;
    logic [`DATA_W-1:0] snp;
  } out_t;
  out_t o_r, o_nxt;
  logic owning, ext_ten_r;
  assign owning = (st_nxt == ST_OWN) || (st_nxt == ST_WR) || (st_nxt == ST_RD);
  always_comb begin
    o_nxt         = o_r;
    o_nxt.wr_rdy  = wr_ready & ~wr_take; // a taken push may fill the last slot
    for (int i = 0; i < `LANES; i++) begin
      o_nxt.dat[i*`LANE_W +: `LANE_W] = lanes[i] ? wr_head.data[i*`LANE_W +: `LANE_W] : 8'h00;
    end
    o_nxt.doe     = (st_nxt == ST_WR);
    o_nxt.par     = par_gen;
    o_nxt.ack_oe  = MC_SLAVE_I && (st_nxt == ST_WR || st_nxt == ST_RD);
    o_nxt.ack_n   = ~o_nxt.ack_oe;
    o_nxt.nob_oe  = o_nxt.ack_oe;
    o_nxt.nob_n   = ~(o_nxt.ack_oe & MC_NO_BURST_I);
    o_nxt.err_oe  = MON_ERR_I;
    o_nxt.err_n   = ~MON_ERR_I;
    o_nxt.req_oe  = ~INT_ARB_EN_I & ~PARKED_I;
    o_nxt.req_n   = ~(st_nxt == ST_REQ);
    o_nxt.gnt_oe  = INT_ARB_EN_I;
    o_nxt.gnt_n   = ~(st_nxt == ST_GRANT);
    o_nxt.busy_oe = owning;
    o_nxt.busy_n  = ~owning;
    o_nxt.rd_v    = (st_r == ST_RD) && end_beat;
    o_nxt.beat    = ((st_r == ST_RD) || (st_r == ST_WR)) && end_beat;
    if (o_nxt.rd_v) begin
      for (int i = 0; i < `LANES; i++) begin
        o_nxt.rd.data[i*`LANE_W +: `LANE_W] = rd_lanes[i] ? d_in[i*`LANE_W +: `LANE_W] : 8'h00;
      end
      o_nxt.rd.lanes    = rd_lanes;
      o_nxt.rd.par_err  = PAR_CHK_EN_I && ((rd_par ^ p_in) & rd_lanes) != `LANES_NONE;
      o_nxt.rd.bus_err  = err_beat;
      o_nxt.rd.no_burst = nob_beat;
    end
    o_nxt.snp_v   = MC_EXT_MASTER_I && (st_r == ST_GRANT) && !busy_in;
    o_nxt.snp     = o_nxt.snp_v ? d_in : o_r.snp;
    o_nxt.ten_end = ext_ten_r & busy_in;
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      o_r       <= '0;
      o_r.ack_n <= 1'b1;
      o_r.err_n <= 1'b1;
      o_r.nob_n <= 1'b1;
      o_r.req_n <= 1'b1;
      o_r.gnt_n <= 1'b1;
      o_r.busy_n <= 1'b1;
      ext_ten_r <= 1'b0;
    end else begin
      o_r       <= o_nxt;
      ext_ten_r <= (st_r == ST_GRANT) & ~busy_in;
    end
  end

  // all outputs straight from flops
  assign WR_READY_O          = o_r.wr_rdy;
  assign DATA_O              = o_r.dat;
  assign DATA_OE_O           = o_r.doe;
  assign PARITY_LINES_O      = o_r.par;
  assign PARITY_LINES_OE_O   = o_r.doe;
  assign TRANSFER_ACK_N_O    = o_r.ack_n;
  assign TRANSFER_ACK_OE_O   = o_r.ack_oe;
  assign ERROR_ACK_N_O       = o_r.err_n;
  assign ERROR_ACK_OE_O      = o_r.err_oe;
  assign NO_BURST_REPLY_N_O  = o_r.nob_n;
  assign NO_BURST_REPLY_OE_O = o_r.nob_oe;
  assign BUS_REQUEST_N_O     = o_r.req_n;
  assign BUS_REQUEST_OE_O    = o_r.req_oe;
  assign BUS_GRANT_N_O       = o_r.gnt_n;
  assign BUS_GRANT_OE_O      = o_r.gnt_oe;
  assign BUS_BUSY_N_O        = o_r.busy_n;
  assign BUS_BUSY_OE_O       = o_r.busy_oe;
  assign RD_VALID_O          = o_r.rd_v;
  assign RD_DATA_O           = o_r.rd.data;
  assign RD_PAR_ERR_O        = o_r.rd.par_err;
  assign RD_BUS_ERR_O        = o_r.rd.bus_err;
  assign RD_NO_BURST_O       = o_r.rd.no_burst;
  assign BEAT_DONE_O         = o_r.beat;
  assign SNOOP_VALID_O       = o_r.snp_v;
  assign SNOOP_DATA_O        = o_r.snp;
  assign EXT_TENURE_END_O    = o_r.ten_end;
endmodule

// File: bench/ext_bus_monitor.sv
/* pin checker for ext_bus_term_arb.
   assumes config inputs change only while the bus is quiet. */
`timescale 1ns/1ps
module ext_bus_monitor (
  // watched ports
  input wire logic CLK_I, RESET_N_I, INT_ARB_EN_I, PARKED_I, PAR_CHK_EN_I, MC_SLAVE_I, MON_ERR_I,
  input wire logic DATA_OE_O, PARITY_LINES_OE_O, TRANSFER_ACK_N_O, TRANSFER_ACK_OE_O, ERROR_ACK_N_O,
  input wire logic ERROR_ACK_OE_O, NO_BURST_REPLY_OE_O, BUS_REQUEST_OE_O, BUS_GRANT_OE_O, BUS_GRANT_N_I,
  input wire logic NO_BURST_REPLY_N_O, MC_NO_BURST_I,
  input wire logic BUS_BUSY_N_O, BUS_BUSY_OE_O, RD_VALID_O, RD_PAR_ERR_O, BEAT_DONE_O
);
  // one domain; [*6] spans the input filter latency
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_drive_owned_bus: assert property (DATA_OE_O |-> BUS_BUSY_OE_O && !BUS_BUSY_N_O)
    else $error("lanes driven off tenure");
  a_parity_with_data: assert property (DATA_OE_O |-> PARITY_LINES_OE_O)
    else $error("parity not driven");
  a_ack_mc_only: assert property ((!MC_SLAVE_I)[*6] |-> !TRANSFER_ACK_OE_O && !NO_BURST_REPLY_OE_O)
    else $error("ack driven for foreign slave");
  a_mc_write_ack: assert property ($rose(DATA_OE_O) && MC_SLAVE_I |-> ##[0:4] !TRANSFER_ACK_N_O)
    else $error("no own ack");
  a_grant_int_only: assert property ((!INT_ARB_EN_I)[*6] |-> !BUS_GRANT_OE_O)
    else $error("grant driven");
  a_req_ext_only: assert property ((INT_ARB_EN_I || PARKED_I)[*6] |-> !BUS_REQUEST_OE_O)
    else $error("request driven");
  a_start_on_grant: assert property ((!INT_ARB_EN_I && BUS_GRANT_N_I)[*6] |-> !DATA_OE_O)
    else $error("write without grant");
  a_parerr_off: assert property ((!PAR_CHK_EN_I)[*8] ##0 RD_VALID_O |-> !RD_PAR_ERR_O)
    else $error("parity error while off");
  a_mon_err_drive: assert property (MON_ERR_I[*6] |-> ERROR_ACK_OE_O && !ERROR_ACK_N_O)
    else $error("monitor error not driven");
  a_mon_err_quiet: assert property ((!MON_ERR_I)[*6] |-> !ERROR_ACK_OE_O)
    else $error("stray error ack");
  a_beat_single: assert property (BEAT_DONE_O |=> !BEAT_DONE_O)
    else $error("beat pulse too long");
  a_mc_no_burst: assert property (TRANSFER_ACK_OE_O && MC_NO_BURST_I |-> !NO_BURST_REPLY_N_O)
    else $error("own burst inhibit missing");
  // main scenarios reached
  cover property (DATA_OE_O && MC_SLAVE_I);
  cover property (RD_VALID_O && RD_PAR_ERR_O);
  cover property (!INT_ARB_EN_I && !BUS_GRANT_N_I && DATA_OE_O);
endmodule

// File: bench/ext_bus_partner.sv
/* far side: one slave, one external master, one external arbiter.
   assumes shared pins resolve here; active-low lines are pulled up. */
`timescale 1ns/1ps
module ext_bus_partner (
  // clock, reset, bench commands
  input wire logic        CLK_I, RESET_N_I, MC_SLAVE_I, PAR_ODD_I, err_c, nob_c, xreq, gnt_en,
  input wire logic [3:0]  wait_c, bad_par,
  input wire logic [31:0] rd_word, DATA_O,
  // block drives
  input wire logic        DATA_OE_O, PARITY_LINES_OE_O, TRANSFER_ACK_N_O, TRANSFER_ACK_OE_O,
  input wire logic        ERROR_ACK_N_O, ERROR_ACK_OE_O, NO_BURST_REPLY_N_O, NO_BURST_REPLY_OE_O,
  input wire logic        BUS_REQUEST_N_O, BUS_REQUEST_OE_O, BUS_GRANT_N_O, BUS_GRANT_OE_O,
  input wire logic        BUS_BUSY_N_O, BUS_BUSY_OE_O,
  input wire logic [3:0]  PARITY_LINES_O,
  // resolved wires
  output logic [31:0]     DATA_I,
  output logic [3:0]      PARITY_LINES_I,
  output logic            TRANSFER_ACK_N_I, ERROR_ACK_N_I, NO_BURST_REPLY_N_I,
  output logic            BUS_REQUEST_N_I, BUS_GRANT_N_I, BUS_BUSY_N_I
);
  logic       s_ack_r, s_ack_nxt, x_busy_r, x_busy_nxt, x_done_r, x_done_nxt, own, s_drv;
  logic [3:0] s_cnt_r, s_cnt_nxt, x_cnt_r, x_cnt_nxt, par;
  // slave holds its answer until released; master keeps the bus 8 cycles
  always_comb begin
    own = BUS_BUSY_OE_O && !BUS_BUSY_N_O;
    s_cnt_nxt = own ? s_cnt_r + {3'h0, s_cnt_r != 4'hf} : 4'h0;
    s_ack_nxt = own && !MC_SLAVE_I && (s_ack_r || s_cnt_r == wait_c);
    x_cnt_nxt = x_busy_r ? x_cnt_r + 4'h1 : 4'h0;
    x_busy_nxt = x_busy_r ? x_cnt_r != 4'h7 :
                 xreq && !x_done_r && BUS_GRANT_OE_O && !BUS_GRANT_N_O && BUS_BUSY_N_I;
    x_done_nxt = xreq && (x_done_r || (x_busy_r && x_cnt_r == 4'h7));
    s_drv = !DATA_OE_O && (s_ack_r || (own && MC_SLAVE_I));
    for (int k = 0; k < 4; k++) par[k] = ^rd_word[k*8 +: 8] ^ PAR_ODD_I;
  end
  // state registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      {s_ack_r, x_busy_r, x_done_r, s_cnt_r, x_cnt_r} <= '0;
    end else begin
      {s_ack_r, x_busy_r, x_done_r, s_cnt_r, x_cnt_r} <= {s_ack_nxt, x_busy_nxt, x_done_nxt, s_cnt_nxt, x_cnt_nxt};
    end
  end
  // released lanes show the inverse, never the last value
  assign DATA_I = DATA_OE_O ? DATA_O : (s_drv || x_busy_r) ? rd_word : ~rd_word;
  assign PARITY_LINES_I = PARITY_LINES_OE_O ? PARITY_LINES_O : s_drv ? par ^ bad_par : ~par;
  assign TRANSFER_ACK_N_I = (TRANSFER_ACK_OE_O ? TRANSFER_ACK_N_O : 1'b1) & !(s_ack_r && !err_c);
  assign ERROR_ACK_N_I = (ERROR_ACK_OE_O ? ERROR_ACK_N_O : 1'b1) & !(s_ack_r && err_c);
  assign NO_BURST_REPLY_N_I = (NO_BURST_REPLY_OE_O ? NO_BURST_REPLY_N_O : 1'b1) & !(s_ack_r && nob_c);
  assign BUS_REQUEST_N_I = (BUS_REQUEST_OE_O ? BUS_REQUEST_N_O : 1'b1) & !(xreq && !x_busy_r && !x_done_r);
  assign BUS_GRANT_N_I = (BUS_GRANT_OE_O ? BUS_GRANT_N_O : 1'b1) & !gnt_en;
  assign BUS_BUSY_N_I = (BUS_BUSY_OE_O ? BUS_BUSY_N_O : 1'b1) & !x_busy_r;
endmodule

// File: bench/testbench.sv
/* self-checking bench for ext_bus_term_arb.
   assumes ext_bus_partner resolves every shared pin. */
`timescale 1ns/1ps
module testbench;
  // block pins and partner commands
  logic        CLK_I, RESET_N_I, INT_ARB_EN_I, PARKED_I, PAR_ODD_I, PAR_CHK_EN_I, MC_SLAVE_I, MC_EXT_MASTER_I;
  logic        MON_ERR_I, MC_NO_BURST_I, WR_VALID_I, WR_READY_O, WR_BURST_I, RD_REQ_I, RD_BURST_I, RD_VALID_O;
  logic        RD_PAR_ERR_O, RD_BUS_ERR_O, RD_NO_BURST_O, BEAT_DONE_O, SNOOP_VALID_O, EXT_TENURE_END_O, DATA_OE_O;
  logic        PARITY_LINES_OE_O, TRANSFER_ACK_N_I, TRANSFER_ACK_N_O, TRANSFER_ACK_OE_O, ERROR_ACK_N_I, ERROR_ACK_N_O;
  logic        ERROR_ACK_OE_O, NO_BURST_REPLY_N_I, NO_BURST_REPLY_N_O, NO_BURST_REPLY_OE_O, BUS_REQUEST_N_I;
  logic        BUS_REQUEST_N_O, BUS_REQUEST_OE_O, BUS_GRANT_N_I, BUS_GRANT_N_O, BUS_GRANT_OE_O, BUS_BUSY_N_I;
  logic        BUS_BUSY_N_O, BUS_BUSY_OE_O, err_c, nob_c, xreq, gnt_en;
  logic [1:0]  WR_ADDR_LO_I, WR_SIZE_I, RD_ADDR_LO_I, RD_SIZE_I;
  logic [3:0]  PARITY_LINES_I, PARITY_LINES_O, wait_c, bad_par;
  logic [31:0] WR_DATA_I, RD_DATA_O, SNOOP_DATA_O, DATA_I, DATA_O, rd_word;
  int          errors, samples_checked, i;

  ext_bus_term_arb u_ext_bus_term_arb (.*);
  ext_bus_partner  u_ext_bus_partner (.*);

  // expected lanes: burst or word takes all four
  function automatic logic [3:0] lmask(logic [1:0] a, logic [1:0] s, logic b);
    logic [3:0] m;
    m = (s == 2'h1) ? 4'h1 : (s == 2'h2) ? 4'h3 : 4'h7;
    return (b || s == 2'h0) ? 4'hf : m << a;
  endfunction
  function automatic logic [31:0] wide(logic [3:0] m);
    for (int k = 0; k < 4; k++) wide[k*8 +: 8] = {8{m[k]}};
  endfunction
  function automatic logic [3:0] epar(logic [31:0] d, logic o);
    for (int k = 0; k < 4; k++) epar[k] = ^d[k*8 +: 8] ^ o;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge CLK_I);
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // push held until the edge that sees ready
  task automatic push(logic [31:0] d, logic [1:0] a, logic [1:0] s, logic b);
    @(posedge CLK_I);
    {WR_DATA_I, WR_ADDR_LO_I, WR_SIZE_I, WR_BURST_I, WR_VALID_I} <= {d, a, s, b, 1'b1};
    do @(posedge CLK_I); while (WR_READY_O !== 1'b1);
    WR_VALID_I <= 1'b0;
  endtask
  task automatic see_write(logic [31:0] d, logic [3:0] m);
    for (i = 0; i < 60 && DATA_OE_O !== 1'b1; i++) @(posedge CLK_I);
    chk(DATA_O & wide(m), d & wide(m));
    chk(PARITY_LINES_O & m, epar(d, PAR_ODD_I) & m);
    chk(BUS_BUSY_N_O, 1'b0);
    for (i = 0; i < 60 && BEAT_DONE_O !== 1'b1; i++) @(posedge CLK_I);
    chk(BEAT_DONE_O, 1'b1);
  endtask
  // read with bad parity lanes bp; pe, be, nb are the expected flags
  task automatic t_read(logic [1:0] a, logic [1:0] s, logic b, logic [3:0] bp, logic pe, logic be, logic nb);
    @(posedge CLK_I);
    {bad_par, RD_ADDR_LO_I, RD_SIZE_I, RD_BURST_I, RD_REQ_I} <= {bp, a, s, b, 1'b1};
    @(posedge CLK_I);
    RD_REQ_I <= 1'b0;
    for (i = 0; i < 80 && RD_VALID_O !== 1'b1; i++) @(posedge CLK_I);
    chk(RD_VALID_O, 1'b1);
    if (!be) chk(RD_DATA_O, rd_word & wide(lmask(a, s, b)));
    chk({RD_PAR_ERR_O, RD_BUS_ERR_O, RD_NO_BURST_O}, {pe, be, nb});
    tick(6);
  endtask

  task automatic t_mc_writes;
    for (int n = 0; n < 5; n++) begin
      PAR_ODD_I <= n[0];
      tick(6);
      push(32'h96c3_5a0f + 32'(n) * 32'h0101_0101, 2'(3 - n), 2'(n) | 2'(n >> 2), n[2]);
      see_write(32'h96c3_5a0f + 32'(n) * 32'h0101_0101, lmask(2'(3 - n), 2'(n) | 2'(n >> 2), n[2]));
    end
  endtask
  task automatic t_reads;
    {MC_SLAVE_I, PAR_CHK_EN_I} <= 2'b01;
    tick(8);
    t_read(2'h0, 2'h0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0);
    wait_c <= 4'h5;
    t_read(2'h2, 2'h1, 1'b0, 4'h1, 1'b0, 1'b0, 1'b0);
    t_read(2'h0, 2'h1, 1'b0, 4'h1, 1'b1, 1'b0, 1'b0);
    t_read(2'h1, 2'h2, 1'b0, 4'h2, 1'b1, 1'b0, 1'b0);
    nob_c <= 1'b1;
    t_read(2'h0, 2'h0, 1'b1, 4'h0, 1'b0, 1'b0, 1'b1);
    {nob_c, err_c} <= 2'b01;
    t_read(2'h0, 2'h0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
    {err_c, PAR_CHK_EN_I} <= 2'b00;
    tick(8);
    t_read(2'h3, 2'h1, 1'b0, 4'h8, 1'b0, 1'b0, 1'b0);
    {MC_SLAVE_I, MC_NO_BURST_I} <= 2'b11;
    tick(8);
    t_read(2'h0, 2'h0, 1'b1, 4'h0, 1'b0, 1'b0, 1'b1);
    MC_NO_BURST_I <= 1'b0;
  endtask
  task automatic t_ext_master;
    {MC_EXT_MASTER_I, xreq} <= 2'b11;
    for (i = 0; i < 60 && BUS_GRANT_N_O !== 1'b0; i++) @(posedge CLK_I);
    chk({BUS_GRANT_OE_O, BUS_GRANT_N_O}, 2'b10);
    for (i = 0; i < 60 && SNOOP_VALID_O !== 1'b1; i++) @(posedge CLK_I);
    chk(SNOOP_DATA_O, rd_word);
    for (i = 0; i < 60 && EXT_TENURE_END_O !== 1'b1; i++) @(posedge CLK_I);
    chk(EXT_TENURE_END_O, 1'b1);
    {MC_EXT_MASTER_I, xreq} <= 2'b00;
  endtask
  // fill the queue behind a withheld grant, then drain it
  task automatic t_ext_arb;
    INT_ARB_EN_I <= 1'b0;
    tick(8);
    for (int n = 0; n < 8; n++) push(32'h0f1e_2d3c + 32'(n), 2'h0, 2'h0, 1'b0);
    tick(6);
    chk({WR_READY_O, DATA_OE_O, BUS_REQUEST_OE_O, BUS_REQUEST_N_O}, 4'b0010);
    gnt_en <= 1'b1;
    for (int n = 0; n < 8; n++) see_write(32'h0f1e_2d3c + 32'(n), 4'hf);
    PARKED_I <= 1'b1;
    tick(8);
    push(32'h7788_99aa, 2'h0, 2'h0, 1'b0);
    see_write(32'h7788_99aa, 4'hf);
  endtask
  task automatic t_mon_err;
    MON_ERR_I <= 1'b1;
    tick(8);
    chk({ERROR_ACK_OE_O, ERROR_ACK_N_O}, 2'b10);
    MON_ERR_I <= 1'b0;
    tick(8);
    chk(ERROR_ACK_OE_O, 1'b0);
  endtask

  // 125 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  // run long past the expected few hundred cycles
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    {RESET_N_I, INT_ARB_EN_I, PARKED_I, PAR_ODD_I, PAR_CHK_EN_I, MC_SLAVE_I, MC_EXT_MASTER_I, MON_ERR_I} = 8'h44;
    {MC_NO_BURST_I, WR_VALID_I, WR_BURST_I, RD_REQ_I, RD_BURST_I, err_c, nob_c, xreq, gnt_en} = 9'h000;
    {WR_DATA_I, WR_ADDR_LO_I, WR_SIZE_I, RD_ADDR_LO_I, RD_SIZE_I, bad_par} = '0;
    {wait_c, rd_word, errors, samples_checked} = {4'h2, 32'ha5c3_1e78, 64'h0};
    tick(3);
    RESET_N_I <= 1'b1;
    tick(8);
    t_mc_writes();
    t_reads();
    t_ext_master();
    t_ext_arb();
    t_mon_err();
    wrap_up();
  end
endmodule

bind ext_bus_term_arb ext_bus_monitor u_ext_bus_monitor (.*);
